// ### logic/ulm_defines.svh
/*
 * Bit positions, reset values and pulse timing for the UART line-mode
 * extensions: RS-485 direction control, multidrop reception and the
 * infrared pulse codec.
 * Assumes the includer works at the UART's 16x baud tick.
 */
// Functional notes
// [RULE1] Without auto direction or flow control, request-to-send follows modem bit 1.
// [RULE2] Divisor-extension bit 6 hands request-to-send to the transmitter, overriding all.
// [RULE3] Auto direction: output high on FIFO write, low after last bit shifted.
// [RULE4] Software turns hardware flow control off before using auto direction.
// [RULE5] RS-485 control bit 5 inverts auto direction polarity: low while sending.
// [RULE6] RS-485 control bit 0 enables 9-bit mode; ninth bit 1 means address.
// [RULE7] Software sets 9-bit mode, detect off and forced parity 0 for multidrop.
// [RULE8] Normal multidrop, receiver off: drop data bytes until an address arrives.
// [RULE9] Normal multidrop address: parity error, store byte, line interrupt if enabled.
// [RULE10] Controller enables the receiver only when the address is its own.
// [RULE11] Enabled receiver keeps taking data; later addresses again flag parity error.
// [RULE12] Auto address mode drops data and non-matching addresses.
// [RULE13] Matching address enables receiver, stores byte with ninth bit, line interrupt.
// [RULE14] Later non-matching address disables receiver and is dropped; match is stored.
// [RULE15] First infrared mode: high pulse of 3/16 bit per 0 bit.
// [RULE16] Second infrared mode: high pulse of 1/4 bit per 0 bit.
// [RULE17] Extension bit 7 enables infrared 3/16; auxiliary bit 4 selects quarter.
// [RULE18] Infrared mode: transmit idles low, low receive input means idle.
// [RULE19] Infrared decoder returns logic 1 for each detected light pulse.
// [RULE20] Encoder centres each pulse in the bit and stays low for 1 bits.
`ifndef ULM_DEFINES_SVH
`define ULM_DEFINES_SVH

// Register bit positions
`define ULM_MODEM_RTS_BIT       1
`define ULM_DIVEXT_AUTO_DIR_BIT 6
`define ULM_DIVEXT_IR_EN_BIT    7
`define ULM_485_NINE_BIT        0
`define ULM_485_INVERT_BIT      5
`define ULM_FEAT_SPECIAL_BIT    5
`define ULM_INTEN_LINE_BIT      2
`define ULM_AUXST_IR_QTR_BIT    4

// Infrared timing in 16x baud ticks
`define ULM_TICKS_PER_BIT    5'h10
`define ULM_PULSE_3_16       4'h3
`define ULM_PULSE_1_4        4'h4
`define ULM_PULSE_START      4'h6

// Reset values
`define ULM_RX_EN_RESET      1'b0
`define ULM_TX_PIN_RESET     1'b1
`define ULM_RTS_PIN_RESET    1'b1

`endif

// ### logic/ulm_pkg.sv
/*
 * Types shared by the line-mode modules.
 * Assumes nothing of its surroundings.
 */
package ulm_pkg;

	typedef logic [7:0] ulm_byte_t;

	// Character as it enters the receive FIFO
	typedef struct packed {
		ulm_byte_t data;
		logic      perr;
	} ulm_char_t;

	// What the multidrop filter does with one character
	typedef enum logic [1:0] {
		ULM_DROP,
		ULM_PASS,
		ULM_ADDR
	} ulm_rx_act_t;

endpackage

// ### logic/ulm_char_if.sv
/*
 * Valid/ready carrier for received characters between the filter and
 * the two-entry buffer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps

interface ulm_char_if;
	import ulm_pkg::*;

	logic      valid;
	logic      ready;
	ulm_char_t chr;

	modport src (output valid, output chr, input ready);
	modport snk (input valid, input chr, output ready);
endinterface

// ### logic/ulm_buf2.sv
/*
 * Two-entry buffer for received characters. Slot 0 is the output
 * register, slot 1 absorbs one word while the sink stalls.
 * Assumes a single clock, and that ce freezes all state.
 */
`timescale 1ns/1ps

module ulm_buf2 (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	// Filling side
	ulm_char_if.snk                in_if,
	// Draining side
	output logic                   out_valid,
	input  wire logic              out_ready,
	output ulm_pkg::ulm_char_t     out_chr
);
	import ulm_pkg::*;

	ulm_char_t slot0_ff, slot1_ff, nxt_slot0, nxt_slot1;
	logic [1:0] cnt_ff, nxt_cnt;
	logic       rdy_ff, nxt_rdy;
	logic       vld_ff, nxt_vld;
	logic       push, pop;

	// Next slot contents and fill count
	always_comb begin
		push      = in_if.valid && rdy_ff;
		pop       = (cnt_ff != 2'h0) && out_ready;
		nxt_slot0 = slot0_ff;
		nxt_slot1 = slot1_ff;
		nxt_cnt   = cnt_ff;
		unique case (cnt_ff)
			2'h0: begin
				if (push) begin
					nxt_slot0 = in_if.chr;
					nxt_cnt   = 2'h1;
				end
			end
			2'h1: begin
				if (push && pop) begin
					nxt_slot0 = in_if.chr;
				end else if (push) begin
					nxt_slot1 = in_if.chr;
					nxt_cnt   = 2'h2;
				end else if (pop) begin
					nxt_cnt = 2'h0;
				end
			end
			2'h2: begin
				if (pop) begin
					nxt_slot0 = slot1_ff;
					nxt_cnt   = 2'h1;
				end
			end
			default: nxt_cnt = 2'h0;
		endcase
		nxt_rdy = (nxt_cnt != 2'h2);
		nxt_vld = (nxt_cnt != 2'h0);
	end

	// Register slots, count and ready
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slot0_ff <= '0;
			slot1_ff <= '0;
			cnt_ff   <= 2'h0;
			rdy_ff   <= 1'b1;
			vld_ff   <= 1'b0;
		end else if (ce) begin
			slot0_ff <= nxt_slot0;
			slot1_ff <= nxt_slot1;
			cnt_ff   <= nxt_cnt;
			rdy_ff   <= nxt_rdy;
			vld_ff   <= nxt_vld;
		end
	end

	assign in_if.ready = rdy_ff;
	assign out_valid   = vld_ff;
	assign out_chr     = slot0_ff;
endmodule

// ### logic/ulm_ir_codec.sv
/*
 * Infrared pulse encoder and decoder, with pass-through when infrared
 * mode is off.
 * Assumes baud_tick16 is a one-cycle enable at 16x the bit rate and
 * tx_bit_start marks the first tick of every transmitted bit.
 */
`timescale 1ns/1ps
`include "ulm_defines.svh"

module ulm_ir_codec (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic ce,
	// Mode
	input  wire logic ir_en,
	input  wire logic ir_quarter,
	// Timing
	input  wire logic baud_tick16,
	input  wire logic tx_bit_start,
	// Serial streams
	input  wire logic tx_serial,
	output logic      tx_pin,
	input  wire logic rx_pin,
	output logic      rx_serial
);
	logic [3:0] phase_ff, nxt_phase;
	logic [4:0] hold_ff, nxt_hold;
	logic       tx_pin_ff, nxt_tx_pin;
	logic       rx_ser_ff, nxt_rx_ser;
	logic [3:0] width;
	logic       in_window;

	// Encoder: phase within the bit and a centred pulse for 0 bits
	always_comb begin
		width = ir_quarter ? `ULM_PULSE_1_4 : `ULM_PULSE_3_16; // [RULE17]
		nxt_phase = phase_ff;
		if (tx_bit_start) begin
			nxt_phase = 4'h0;
		end else if (baud_tick16) begin
			nxt_phase = phase_ff + 4'h1;
		end
		in_window = (phase_ff >= `ULM_PULSE_START) &&
			(phase_ff < `ULM_PULSE_START + width); // [RULE15] [RULE16]
		if (ir_en) begin
			nxt_tx_pin = in_window && !tx_serial; // [RULE18] [RULE20]
		end else begin
			nxt_tx_pin = tx_serial;
		end
	end

	// Decoder: a light pulse yields a 1 held for one bit time
	always_comb begin
		nxt_hold = hold_ff;
		if (ir_en && rx_pin) begin
			nxt_hold = `ULM_TICKS_PER_BIT;
		end else if (baud_tick16 && hold_ff != 5'h00) begin
			nxt_hold = hold_ff - 5'h01;
		end
		if (ir_en) begin
			nxt_rx_ser = rx_pin || (hold_ff != 5'h00); // [RULE19] [RULE18]
		end else begin
			nxt_rx_ser = rx_pin;
		end
	end

	// Register codec state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_ff  <= 4'h0;
			hold_ff   <= 5'h00;
			tx_pin_ff <= `ULM_TX_PIN_RESET;
			rx_ser_ff <= 1'b1;
		end else if (ce) begin
			phase_ff  <= nxt_phase;
			hold_ff   <= nxt_hold;
			tx_pin_ff <= nxt_tx_pin;
			rx_ser_ff <= nxt_rx_ser;
		end
	end

	assign tx_pin    = tx_pin_ff;
	assign rx_serial = rx_ser_ff;
endmodule

// ### logic/ulm_line_modes.sv
/*
 * Line-side extension modes of one UART channel: RS-485 direction
 * control on request-to-send, 9-bit multidrop reception with software
 * or automatic address filtering, and the infrared pulse codec.
 * Assumes the UART core supplies the 16x baud tick, transmitter events
 * and received characters with their ninth bit, all on clk, and that
 * the register values arrive as plain ports.
 */
`timescale 1ns/1ps
`include "ulm_defines.svh"

module ulm_line_modes (
	// Clock, reset and enable
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	// Register values
	input  wire ulm_pkg::ulm_byte_t modem_control_reg,
	input  wire ulm_pkg::ulm_byte_t divisor_extension_reg,
	input  wire ulm_pkg::ulm_byte_t rs485_ctrl_reg,
	input  wire ulm_pkg::ulm_byte_t enhanced_feature_reg,
	input  wire ulm_pkg::ulm_byte_t interrupt_enable_reg,
	input  wire ulm_pkg::ulm_byte_t second_xoff_char_reg,
	input  wire ulm_pkg::ulm_byte_t auxiliary_status_reg,
	// Hardware flow control
	input  wire logic              hw_flow_en,
	input  wire logic              hw_flow_rts,
	// Software receiver enable
	input  wire logic              rx_enable_set,
	input  wire logic              rx_enable_clr,
	output logic                   rx_enabled,
	// Transmitter events and stream
	input  wire logic              baud_tick16,
	input  wire logic              tx_fifo_write,
	input  wire logic              tx_all_sent,
	input  wire logic              tx_bit_start,
	input  wire logic              tx_serial,
	// Line pins
	output logic                   tx_pin,
	output logic                   rts_pin,
	input  wire logic              rx_pin,
	output logic                   rx_serial,
	// Characters from the receiver
	input  wire logic              rx_char_valid,
	output logic                   rx_char_ready,
	input  wire ulm_pkg::ulm_byte_t rx_char_data,
	input  wire logic              rx_char_ninth,
	input  wire logic              rx_char_perr,
	// Characters toward the receive FIFO
	output logic                   out_valid,
	input  wire logic              out_ready,
	output ulm_pkg::ulm_byte_t     out_data,
	output logic                   out_perr,
	output logic                   line_status_irq
);
	import ulm_pkg::*;

	ulm_char_if chr_if ();
	ulm_char_t  out_chr;

	// Decoded control bits
	logic auto_dir;
	logic rts_invert;
	logic nine_bit;
	logic special;
	logic line_irq_en;

	assign auto_dir    = divisor_extension_reg[`ULM_DIVEXT_AUTO_DIR_BIT];
	assign rts_invert  = rs485_ctrl_reg[`ULM_485_INVERT_BIT];
	assign nine_bit    = rs485_ctrl_reg[`ULM_485_NINE_BIT]; // [RULE6]
	assign special     = enhanced_feature_reg[`ULM_FEAT_SPECIAL_BIT];
	assign line_irq_en = interrupt_enable_reg[`ULM_INTEN_LINE_BIT];

	// ------------------------------------------------------------
	// Transmit direction control
	// ------------------------------------------------------------
	logic pend_ff, nxt_pend;
	logic rts_ff, nxt_rts;

	// Pending data flag and request-to-send source selection
	always_comb begin
		nxt_pend = pend_ff;
		if (tx_all_sent) begin
			nxt_pend = 1'b0;
		end
		// A write landing with the last bit keeps the line turned
		if (tx_fifo_write) begin
			nxt_pend = 1'b1; // [RULE3]
		end
		if (auto_dir) begin
			// Transmitter owns the pin; flow control is assumed off
			nxt_rts = nxt_pend ^ rts_invert; // [RULE2] [RULE3] [RULE5] [RULE4]
		end else if (hw_flow_en) begin
			nxt_rts = hw_flow_rts; // [RULE1]
		end else begin
			nxt_rts = modem_control_reg[`ULM_MODEM_RTS_BIT]; // [RULE1]
		end
	end

	// Register direction state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_ff <= 1'b0;
			rts_ff  <= `ULM_RTS_PIN_RESET;
		end else if (ce) begin
			pend_ff <= nxt_pend;
			rts_ff  <= nxt_rts;
		end
	end

	assign rts_pin = rts_ff;

	// ------------------------------------------------------------
	// Multidrop receive filter
	// ------------------------------------------------------------
	ulm_rx_act_t act;
	logic        taken;
	logic        addr_match;
	logic        hw_en_set;
	logic        hw_en_clr;
	logic        rx_en_ff, nxt_rx_en;
	logic        irq_ff, nxt_irq;
	logic        chr_perr;

	// Classify the offered character
	always_comb begin
		taken      = rx_char_valid && chr_if.ready;
		addr_match = (rx_char_data == second_xoff_char_reg);
		hw_en_set  = 1'b0;
		hw_en_clr  = 1'b0;
		act        = ULM_PASS;
		chr_perr   = rx_char_perr;
		if (nine_bit && special) begin
			// Automatic address matching
			if (rx_char_ninth && addr_match) begin
				act       = ULM_ADDR; // [RULE13] [RULE14]
				chr_perr  = rx_char_ninth;
				hw_en_set = taken;
			end else if (rx_char_ninth) begin
				act       = ULM_DROP; // [RULE12] [RULE14]
				hw_en_clr = taken;
			end else if (!rx_en_ff) begin
				act = ULM_DROP; // [RULE12]
			end else begin
				chr_perr = 1'b0;
			end
		end else if (nine_bit) begin
			// Software address filtering
			if (rx_char_ninth) begin
				act      = ULM_ADDR; // [RULE9] [RULE11]
				chr_perr = 1'b1;
			end else if (!rx_en_ff) begin
				act = ULM_DROP; // [RULE8]
			end else begin
				chr_perr = 1'b0; // [RULE11]
			end
		end
	end

	// Receiver enable: any set beats any clear in the same cycle
	always_comb begin
		nxt_rx_en = rx_en_ff;
		if (hw_en_clr || rx_enable_clr) begin
			nxt_rx_en = 1'b0; // [RULE14]
		end
		if (hw_en_set || rx_enable_set) begin
			nxt_rx_en = 1'b1; // [RULE13]
		end
		nxt_irq = taken && (act == ULM_ADDR) && line_irq_en; // [RULE9] [RULE13]
	end

	// Register receiver state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_en_ff <= `ULM_RX_EN_RESET;
			irq_ff   <= 1'b0;
		end else if (ce) begin
			rx_en_ff <= nxt_rx_en;
			irq_ff   <= nxt_irq;
		end
	end

	// Forward kept characters into the buffer
	assign chr_if.valid     = rx_char_valid && (act != ULM_DROP);
	assign chr_if.chr       = {rx_char_data, chr_perr};

	assign rx_enabled      = rx_en_ff;
	assign line_status_irq = irq_ff;
	assign rx_char_ready   = chr_if.ready;

	// Two-entry buffer toward the receive FIFO
	ulm_buf2 u_buf (
		.clk       (clk),
		.nrst      (nrst),
		.ce        (ce),
		.in_if     (chr_if.snk),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_chr   (out_chr)
	);

	assign out_data = out_chr.data;
	assign out_perr = out_chr.perr;

	// ------------------------------------------------------------
	// Infrared codec
	// ------------------------------------------------------------
	ulm_ir_codec u_ir (
		.clk          (clk),
		.nrst         (nrst),
		.ce           (ce),
		.ir_en        (divisor_extension_reg[`ULM_DIVEXT_IR_EN_BIT]),
		.ir_quarter   (auxiliary_status_reg[`ULM_AUXST_IR_QTR_BIT]),
		.baud_tick16  (baud_tick16),
		.tx_bit_start (tx_bit_start),
		.tx_serial    (tx_serial),
		.tx_pin       (tx_pin),
		.rx_pin       (rx_pin),
		.rx_serial    (rx_serial)
	); // [RULE17]
endmodule

// ### test/ulm_line_xcvr.sv
/*
 * Model of the line transceiver on the far side of the line pins.
 * Assumes one clock; the bench calls flash() to light the receive diode.
 */
`timescale 1ns/1ps

module ulm_line_xcvr (
	// Clock and mode
	input  wire logic clk,
	input  wire logic ir_mode,
	// Line
	input  wire logic tx_pin,
	output logic      rx_pin,
	// Observed transmit pulses
	output int        pulse_cnt,
	output int        pulse_len
);
	int   run;
	logic light;

	// Receive line idles low in infrared mode, high otherwise
	assign rx_pin = light ? 1'b1 : !ir_mode;

	initial begin
		light = 1'b0;
		run = 0;
		pulse_cnt = 0;
		pulse_len = 0;
	end

	// Width of each high pulse, recorded as it ends
	always @(posedge clk) begin
		if (tx_pin) begin
			run <= run + 1;
		end else begin
			if (run != 0) begin
				pulse_cnt <= pulse_cnt + 1;
				pulse_len <= run;
			end
			run <= 0;
		end
	end

	// Light pulse on the receive diode for n cycles
	task automatic flash(input int n);
		light <= 1'b1;
		repeat (n) @(posedge clk);
		light <= 1'b0;
	endtask
endmodule

// ### test/ulm_line_modes_chk.sv
/*
 * Concurrent checks on the ports of the line-mode block.
 * Assumes one clock domain; bound into every instance below.
 */
`timescale 1ns/1ps

module ulm_line_modes_chk (
	// Clock and control
	input wire logic               clk,
	input wire logic               nrst,
	input wire logic               ce,
	// Register values
	input wire ulm_pkg::ulm_byte_t modem_control_reg,
	input wire ulm_pkg::ulm_byte_t divisor_extension_reg,
	input wire ulm_pkg::ulm_byte_t rs485_ctrl_reg,
	input wire ulm_pkg::ulm_byte_t enhanced_feature_reg,
	input wire ulm_pkg::ulm_byte_t interrupt_enable_reg,
	input wire ulm_pkg::ulm_byte_t second_xoff_char_reg,
	// Direction control
	input wire logic               hw_flow_en,
	input wire logic               hw_flow_rts,
	input wire logic               tx_fifo_write,
	input wire logic               tx_all_sent,
	input wire logic               rts_pin,
	// Infrared
	input wire logic               tx_serial,
	input wire logic               tx_pin,
	input wire logic               rx_pin,
	input wire logic               rx_serial,
	// Characters
	input wire logic               rx_enable_set,
	input wire logic               rx_enabled,
	input wire logic               rx_char_valid,
	input wire logic               rx_char_ready,
	input wire ulm_pkg::ulm_byte_t rx_char_data,
	input wire logic               rx_char_ninth,
	input wire logic               out_valid,
	input wire ulm_pkg::ulm_byte_t out_data,
	input wire logic               out_perr,
	input wire logic               line_status_irq
);
	import ulm_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Decoded modes and the receive take
	wire tk   = ce && rx_char_valid && rx_char_ready;
	wire nine = rs485_ctrl_reg[0];
	wire spc  = enhanced_feature_reg[5];
	wire adir = divisor_extension_reg[6];
	wire ir   = divisor_extension_reg[7];
	wire hit  = rx_char_data == second_xoff_char_reg;

	// Address taken in normal mode, then stored flagged; matching address taken in automatic mode
	sequence addr_taken;
		tk && nine && !spc && rx_char_ninth && !out_valid;
	endsequence
	sequence addr_stored;
		out_valid && out_perr;
	endsequence
	sequence match_taken;
		tk && nine && spc && rx_char_ninth && hit;
	endsequence

	manual_rts_a: assert property (ce && !adir && !hw_flow_en
		|=> rts_pin == $past(modem_control_reg[1])) else $error("rts bad");
	flow_rts_a: assert property (ce && !adir && hw_flow_en
		|=> rts_pin == $past(hw_flow_rts)) else $error("flow rts bad");
	dir_raise_a: assert property (ce && adir && tx_fifo_write
		|=> rts_pin != $past(rs485_ctrl_reg[5])) else $error("no raise");
	dir_drop_a: assert property (ce && adir && tx_all_sent
		&& !tx_fifo_write |=> rts_pin == $past(rs485_ctrl_reg[5]))
		else $error("no drop");
	addr_flag_a: assert property (addr_taken |=> addr_stored
		##0 out_data == $past(rx_char_data)) else $error("addr lost");
	addr_irq_a: assert property (tk && nine && rx_char_ninth
		&& (!spc || hit) && interrupt_enable_reg[2] |=> line_status_irq)
		else $error("no irq");
	data_drop_a: assert property (tk && nine && !rx_char_ninth
		&& !rx_enabled && !out_valid |=> !out_valid)
		else $error("data kept");
	match_on_a: assert property (match_taken |=> rx_enabled)
		else $error("match not enabled");
	miss_off_a: assert property (tk && nine && spc && rx_char_ninth
		&& !hit && !rx_enable_set && !out_valid
		|=> !rx_enabled && !out_valid) else $error("miss kept");
	ir_dark_a: assert property (ce && ir && tx_serial
		|=> !tx_pin) else $error("light on one");
	ir_decode_a: assert property (ce && ir && rx_pin
		|=> rx_serial) else $error("pulse missed");
endmodule

bind ulm_line_modes ulm_line_modes_chk ulm_line_modes_chk_i (.*);

// ### test/test_ulm_line_modes.sv
/*
 * Self-checking bench for the line-mode block.
 * Assumes register values as plain ports and a line model on the pins.
 */
`timescale 1ns/1ps

module test_ulm_line_modes;
	import ulm_pkg::*;

	logic clk, nrst, ce, hw_flow_en, hw_flow_rts, rx_enable_set;
	logic rx_enable_clr, rx_enabled, baud_tick16, tx_fifo_write;
	logic tx_all_sent, tx_bit_start, tx_serial, tx_pin, rts_pin;
	logic rx_pin, rx_serial, rx_char_valid, rx_char_ready;
	logic rx_char_ninth, rx_char_perr, out_valid, out_ready, out_perr;
	logic line_status_irq;
	ulm_byte_t modem_control_reg, divisor_extension_reg, rs485_ctrl_reg;
	ulm_byte_t enhanced_feature_reg, interrupt_enable_reg;
	ulm_byte_t second_xoff_char_reg, auxiliary_status_reg;
	ulm_byte_t rx_char_data, out_data;
	logic [4:0]  phase;
	logic [3:0]  bit_idx;
	logic [15:0] tx_pat;
	int          pulse_cnt, pulse_len, n0, miscompares, checked;

	ulm_line_modes ulm_line_modes_i (.*);
	ulm_line_xcvr ulm_line_xcvr_i (.clk(clk),
		.ir_mode(divisor_extension_reg[7]), .tx_pin(tx_pin),
		.rx_pin(rx_pin), .pulse_cnt(pulse_cnt), .pulse_len(pulse_len));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Tick every second cycle, a new bit every 32 cycles
	always @(posedge clk) begin
		phase <= phase + 5'h01;
		baud_tick16 <= !phase[0];
		tx_bit_start <= phase == 5'h00;
		if (phase == 5'h00) begin
			tx_serial <= tx_pat[bit_idx];
			bit_idx <= bit_idx + 4'h1;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input string what, input logic [8:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Offer {ninth, data} until taken; caller waits an edge after
	task automatic send(input logic [8:0] c, input logic pe);
		rx_char_valid <= 1'b1;
		{rx_char_ninth, rx_char_data} <= c;
		rx_char_perr <= pe;
		do @(posedge clk); while (rx_char_ready !== 1'b1);
		rx_char_valid <= 1'b0;
	endtask

	// Take one character and compare {perr, data}
	task automatic pop(input logic [8:0] exp);
		out_ready <= 1'b1;
		do @(posedge clk); while (out_valid !== 1'b1);
		chk("rx char", {out_perr, out_data}, exp);
		out_ready <= 1'b0;
		tick(1);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		tick(20000);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		{modem_control_reg, divisor_extension_reg, rs485_ctrl_reg} = '0;
		{enhanced_feature_reg, interrupt_enable_reg} = '0;
		{second_xoff_char_reg, auxiliary_status_reg, rx_char_data} = '0;
		{hw_flow_en, hw_flow_rts, rx_enable_set, rx_enable_clr} = '0;
		{tx_fifo_write, tx_all_sent, rx_char_valid, rx_char_ninth} = '0;
		{rx_char_perr, out_ready, baud_tick16, tx_bit_start} = '0;
		{ce, tx_serial, nrst} = 3'b110;
		{phase, bit_idx, tx_pat} = {9'h000, 16'hffff};
		tick(6);
		nrst <= 1'b1;
		// Manual and flow-controlled request-to-send
		modem_control_reg <= 8'h02;
		tick(3);
		chk("rts", rts_pin, 1);
		chk("tx plain", tx_pin, 1);
		hw_flow_en <= 1'b1;
		tick(2);
		chk("rts flow", rts_pin, 0);
		// Clock enable low freezes the pin though its source changes
		ce <= 1'b0;
		hw_flow_en <= 1'b0;
		tick(3);
		chk("rts frozen", rts_pin, 0);
		ce <= 1'b1;
		$display("test rts manual done");
		// Transmitter-driven direction, both polarities
		hw_flow_en <= 1'b0;
		divisor_extension_reg <= 8'h40;
		tick(2);
		chk("rts auto", rts_pin, 0);
		for (int inv = 0; inv < 2; inv++) begin
			rs485_ctrl_reg <= inv ? 8'h20 : 8'h00;
			tx_fifo_write <= 1'b1;
			tick(1);
			tx_fifo_write <= 1'b0;
			tick(1);
			chk("rts raise", rts_pin, !inv);
			tx_all_sent <= 1'b1;
			tick(1);
			tx_all_sent <= 1'b0;
			tick(1);
			chk("rts drop", rts_pin, inv);
		end
		$display("test rts auto done");
		// Normal multidrop under software control
		divisor_extension_reg <= 8'h00;
		rs485_ctrl_reg <= 8'h01;
		interrupt_enable_reg <= 8'h04;
		send(9'h011, 1'b0);
		tick(3);
		chk("drop", out_valid, 0);
		send(9'h1a5, 1'b0);
		tick(1);
		chk("irq", line_status_irq, 1);
		pop(9'h1a5);
		rx_enable_set <= 1'b1;
		tick(1);
		rx_enable_set <= 1'b0;
		send(9'h03c, 1'b0);
		tick(1);
		pop(9'h03c);
		interrupt_enable_reg <= 8'h00;
		send(9'h1b7, 1'b0);
		tick(1);
		chk("irq off", line_status_irq, 0);
		pop(9'h1b7);
		rx_enable_clr <= 1'b1;
		tick(1);
		rx_enable_clr <= 1'b0;
		tick(1);
		chk("rx off", rx_enabled, 0);
		$display("test multidrop done");
		// Automatic address matching
		enhanced_feature_reg <= 8'h20;
		second_xoff_char_reg <= 8'h5a;
		interrupt_enable_reg <= 8'h04;
		send(9'h05a, 1'b0);
		tick(1);
		send(9'h133, 1'b0);
		tick(3);
		chk("auto drop", out_valid, 0);
		send(9'h15a, 1'b0);
		tick(1);
		chk("irq", line_status_irq, 1);
		chk("rx on", rx_enabled, 1);
		pop(9'h15a);
		send(9'h042, 1'b0);
		tick(1);
		pop(9'h042);
		send(9'h15a, 1'b0);
		tick(1);
		pop(9'h15a);
		send(9'h133, 1'b0);
		tick(1);
		chk("rx miss", rx_enabled, 0);
		tick(1);
		chk("miss drop", out_valid, 0);
		$display("test auto address done");
		// Two-entry buffer under a stalled sink
		{rs485_ctrl_reg, enhanced_feature_reg} <= '0;
		send(9'h011, 1'b1);
		tick(1);
		send(9'h022, 1'b0);
		tick(1);
		chk("full", rx_char_ready, 0);
		pop(9'h111);
		send(9'h033, 1'b0);
		tick(1);
		pop(9'h022);
		pop(9'h033);
		$display("test buffer done");
		// Infrared pulse widths, counts and idle levels
		divisor_extension_reg <= 8'h80;
		tx_pat <= 16'hf0f0;
		for (int q = 0; q < 2; q++) begin
			auxiliary_status_reg <= q ? 8'h10 : 8'h00;
			tick(512);
			n0 = pulse_cnt;
			tick(512);
			chk("pulses", 9'(pulse_cnt - n0), 8);
			chk("width", 9'(pulse_len), q ? 8 : 6);
		end
		tx_pat <= 16'hffff;
		tick(512);
		n0 = pulse_cnt;
		tick(512);
		chk("dark", 9'(pulse_cnt - n0), 0);
		chk("tx idle", tx_pin, 0);
		chk("rx idle", rx_serial, 0);
		ulm_line_xcvr_i.flash(3);
		chk("rx pulse", rx_serial, 1);
		$display("test infrared done");
		tally_and_finish();
	end
endmodule
